// ===== shared/ssp_pkg.sv
package ssp_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] ADDR_DATA_BUFFER = 32'hb7b01000;
  localparam logic [31:0] ADDR_STATUS = 32'hb7b01004;
  localparam logic [31:0] ADDR_IRQ_REQUEST = 32'hb7b01008;
  localparam logic [31:0] ADDR_IRQ_ENABLE = 32'hb7b0100c;
  localparam logic [31:0] ADDR_CONTROL = 32'hb7b01010;
  localparam logic [31:0] ADDR_TEST_CONTROL = 32'hb7b01014;

  // ==========================================================
  // Field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OVERRUN_BIT = 1;
  localparam int IRQ_TX_DONE_BIT = 0;
  localparam int IRQ_RX_DONE_BIT = 1;
  localparam int IRQ_EMPTY_BIT = 2;
  localparam int CTRL_SLAVE_BIT = 4;
  localparam int CTRL_MSB_BIT = 5;
  localparam int TEST_LOOP_BIT = 7;

  // ==========================================================
  // Values after reset, counts and response codes
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] COUNT_LAST = 3'h7;
  localparam logic [4:0] DIV8_HALF_CYCLES = 5'h04;
  localparam logic [4:0] DIV16_HALF_CYCLES = 5'h08;
  localparam logic [4:0] DIV32_HALF_CYCLES = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_LOAD = 2'b01,
    SSP_SHIFT = 2'b10
  } ssp_phase_t;

  typedef struct packed {
    ssp_phase_t phase;
    logic [7:0] tx_buf;
    logic tx_pending;
    logic [7:0] shift;
    logic [2:0] shift_count;
    logic [7:0] rx_buf;
    logic rx_unread;
    logic overrun_flag;
    logic [2:0] irq_request;
    logic [2:0] irq_enable;
    logic [1:0] shift_clock_divider_sel;
    logic slave_select_bit;
    logic msb_first_bit;
    logic loopback_enable;
    logic [4:0] div_cnt;
    logic sclk;
    logic clk_drive;
    logic sclk_in_prev;
    logic tx_out;
    logic irq;
    logic aw_held;
    logic [31:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ssp_state_t;

  localparam ssp_state_t STATE_RESET = '{
    phase: SSP_IDLE,
    sclk: 1'b1,
    clk_drive: 1'b1,
    sclk_in_prev: 1'b1,
    tx_out: 1'b1,
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    default: '0
  };

endpackage

// ===== design/ssp_sync_serial_port.sv
module ssp_sync_serial_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_rx_in,
  output logic serial_tx_out,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  output logic irq
);

  ssp_pkg::ssp_state_t state_reg;
  ssp_pkg::ssp_state_t state_next;

  logic wr_go;
  logic wr_buf;
  logic wr_stat;
  logic wr_irq;
  logic frame_done;
  logic ev_empty;
  logic ev_tx_done;
  logic ev_rx_done;
  logic ev_overrun;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [4:0] half;
    logic fall;
    logic rise;
    logic rx_bit;
    logic [7:0] shifted;
    logic [7:0] rd;
    logic rd_ok;
    logic wr_ok;
    state_next = state_reg;
    half = ssp_pkg::DIV32_HALF_CYCLES;
    fall = 1'b0;
    rise = 1'b0;
    rx_bit = 1'b0;
    shifted = 8'h00;
    rd = 8'h00;
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    wr_go = 1'b0;
    wr_buf = 1'b0;
    wr_stat = 1'b0;
    wr_irq = 1'b0;
    frame_done = 1'b0;
    ev_empty = 1'b0;
    ev_tx_done = 1'b0;
    ev_rx_done = 1'b0;
    ev_overrun = 1'b0;

    // ========================================================
    // Serial engine
    case (state_reg.shift_clock_divider_sel)
      2'b00: half = ssp_pkg::DIV8_HALF_CYCLES;
      2'b01: half = ssp_pkg::DIV16_HALF_CYCLES;
      default: half = ssp_pkg::DIV32_HALF_CYCLES;
    endcase
    rx_bit = state_reg.loopback_enable ? state_reg.tx_out : serial_rx_in;
    state_next.sclk_in_prev = sclk_in;
    case (state_reg.phase)
      ssp_pkg::SSP_LOAD: begin
        state_next.shift = state_reg.tx_buf;
        state_next.tx_pending = 1'b0;
        ev_empty = 1'b1;
        state_next.phase = ssp_pkg::SSP_SHIFT;
        state_next.div_cnt = 5'h00;
        state_next.shift_count = 3'h0;
      end
      ssp_pkg::SSP_SHIFT: begin
        if (!state_reg.slave_select_bit) begin
          // Master: toggle the driven clock every half period
          if (state_reg.div_cnt == half - 5'h01) begin
            state_next.div_cnt = 5'h00;
            state_next.sclk = ~state_reg.sclk;
            fall = state_reg.sclk;
            rise = ~state_reg.sclk;
          end else begin
            state_next.div_cnt = state_reg.div_cnt + 5'h01;
          end
        end else begin
          fall = state_reg.sclk_in_prev & ~sclk_in;
          rise = ~state_reg.sclk_in_prev & sclk_in;
        end
        if (fall) begin
          state_next.tx_out = state_reg.msb_first_bit ? state_reg.shift[7] : state_reg.shift[0];
        end
        if (rise) begin
          if (state_reg.msb_first_bit) begin
            shifted = {state_reg.shift[6:0], rx_bit};
          end else begin
            shifted = {rx_bit, state_reg.shift[7:1]};
          end
          state_next.shift = shifted;
          state_next.shift_count = state_reg.shift_count + 3'h1;
          if (state_reg.shift_count == ssp_pkg::COUNT_LAST) begin
            frame_done = 1'b1;
            state_next.rx_buf = shifted;
            ev_rx_done = 1'b1;
            ev_overrun = state_reg.rx_unread;
            state_next.rx_unread = 1'b1;
            if (state_reg.tx_pending) begin
              state_next.shift = state_reg.tx_buf;
              state_next.tx_pending = 1'b0;
              ev_empty = 1'b1;
            end else begin
              state_next.phase = ssp_pkg::SSP_IDLE;
              ev_tx_done = 1'b1;
            end
          end
        end
      end
      default: begin
        state_next.div_cnt = 5'h00;
      end
    endcase

    // ========================================================
    // Write channel
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata[7:0];
      state_next.w_strb0 = s_axi_wstrb[0];
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.aw_held && state_reg.w_held) begin
      wr_go = 1'b1;
      wr_ok = 1'b1;
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      if (state_reg.aw_addr == ssp_pkg::ADDR_DATA_BUFFER) begin
        wr_buf = state_reg.w_strb0;
      end else if (state_reg.aw_addr == ssp_pkg::ADDR_STATUS) begin
        wr_stat = state_reg.w_strb0;
      end else if (state_reg.aw_addr == ssp_pkg::ADDR_IRQ_REQUEST) begin
        wr_irq = state_reg.w_strb0;
      end else if (state_reg.aw_addr == ssp_pkg::ADDR_IRQ_ENABLE) begin
        if (state_reg.w_strb0) begin
          state_next.irq_enable = state_reg.w_data[2:0];
        end
      end else if (state_reg.aw_addr == ssp_pkg::ADDR_CONTROL) begin
        if (state_reg.w_strb0) begin
          state_next.shift_clock_divider_sel = state_reg.w_data[1:0];
          state_next.slave_select_bit = state_reg.w_data[ssp_pkg::CTRL_SLAVE_BIT];
          state_next.msb_first_bit = state_reg.w_data[ssp_pkg::CTRL_MSB_BIT];
        end
      end else if (state_reg.aw_addr == ssp_pkg::ADDR_TEST_CONTROL) begin
        if (state_reg.w_strb0) begin
          state_next.loopback_enable = state_reg.w_data[ssp_pkg::TEST_LOOP_BIT];
        end
      end else begin
        wr_ok = 1'b0;
      end
      state_next.bresp = wr_ok ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
    end
    if (wr_buf) begin
      state_next.tx_buf = state_reg.w_data;
      state_next.tx_pending = 1'b1;
      // A byte landing as the frame ends must still start the next frame
      if (state_next.phase == ssp_pkg::SSP_IDLE) begin
        state_next.phase = ssp_pkg::SSP_LOAD;
      end
    end
    if (wr_stat) begin
      state_next.overrun_flag = state_reg.w_data[ssp_pkg::STAT_OVERRUN_BIT];
      // Busy one while idle is ignored; count bits are never written
      if (state_reg.phase != ssp_pkg::SSP_IDLE && !state_reg.w_data[ssp_pkg::STAT_BUSY_BIT]) begin
        state_next.phase = ssp_pkg::SSP_IDLE;
        state_next.shift_count = 3'h0;
        state_next.tx_pending = 1'b0;
        state_next.div_cnt = 5'h00;
        state_next.sclk = 1'b1;
      end
    end
    if (wr_irq) begin
      state_next.irq_request = state_reg.irq_request & ~state_reg.w_data[2:0];
    end

    // ========================================================
    // Read channel
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_reg.arready) begin
      rd_ok = 1'b1;
      if (s_axi_araddr == ssp_pkg::ADDR_DATA_BUFFER) begin
        rd = state_reg.rx_buf;
        state_next.rx_unread = 1'b0;
      end else if (s_axi_araddr == ssp_pkg::ADDR_STATUS) begin
        rd = {state_reg.shift_count, 3'h0, state_reg.overrun_flag, state_reg.phase != ssp_pkg::SSP_IDLE};
      end else if (s_axi_araddr == ssp_pkg::ADDR_IRQ_REQUEST) begin
        rd = {5'h00, state_reg.irq_request};
      end else if (s_axi_araddr == ssp_pkg::ADDR_IRQ_ENABLE) begin
        rd = {5'h00, state_reg.irq_enable};
      end else if (s_axi_araddr == ssp_pkg::ADDR_CONTROL) begin
        rd = {2'h0, state_reg.msb_first_bit, state_reg.slave_select_bit, 2'h0,
              state_reg.shift_clock_divider_sel};
      end else if (s_axi_araddr == ssp_pkg::ADDR_TEST_CONTROL) begin
        rd = {state_reg.loopback_enable, 7'h00};
      end else begin
        rd_ok = 1'b0;
      end
      state_next.rvalid = 1'b1;
      state_next.rdata = rd;
      state_next.rresp = rd_ok ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
    end

    // ========================================================
    // Hardware events win over software clears
    if (ev_rx_done) begin
      state_next.rx_unread = 1'b1;
    end
    if (ev_overrun) begin
      state_next.overrun_flag = 1'b1;
    end
    state_next.irq_request = state_next.irq_request | {ev_empty, ev_rx_done, ev_tx_done};
    state_next.irq = |(state_next.irq_request & state_next.irq_enable);
    state_next.awready = !state_next.aw_held && !state_next.bvalid;
    state_next.wready = !state_next.w_held && !state_next.bvalid;
    state_next.arready = !state_next.rvalid;
    state_next.clk_drive = !state_next.slave_select_bit;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ssp_pkg::STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rdata = {24'h000000, state_reg.rdata};
  assign serial_tx_out = state_reg.tx_out;
  assign sclk_out = state_reg.sclk;
  assign sclk_oe = state_reg.clk_drive;
  assign irq = state_reg.irq;

  // ==========================================================
  // Checks
  sequence buf_write_idle_s;
    wr_buf && state_reg.phase == ssp_pkg::SSP_IDLE;
  endsequence

  sequence load_then_shift_s;
    state_reg.phase == ssp_pkg::SSP_LOAD ##1
      (state_reg.phase == ssp_pkg::SSP_SHIFT && state_reg.irq_request[ssp_pkg::IRQ_EMPTY_BIT]);
  endsequence

  load_one_cycle_a: assert property (buf_write_idle_s |=> load_then_shift_s)
    else $error("buffer load did not follow write by one cycle");

  busy_clears_done_a: assert property (
    frame_done && !state_reg.tx_pending && !wr_stat && !wr_buf |=>
      state_reg.phase == ssp_pkg::SSP_IDLE && state_reg.irq_request[ssp_pkg::IRQ_TX_DONE_BIT])
    else $error("busy or tx done wrong after last frame");

  abort_init_a: assert property (
    wr_stat && !state_reg.w_data[ssp_pkg::STAT_BUSY_BIT] && state_reg.phase != ssp_pkg::SSP_IDLE |=>
      state_reg.phase == ssp_pkg::SSP_IDLE && state_reg.shift_count == 3'h0 && !state_reg.tx_pending)
    else $error("abort did not reinitialise channel");

  idle_busy_ignored_a: assert property (
    wr_stat && state_reg.phase == ssp_pkg::SSP_IDLE |=> state_reg.phase == ssp_pkg::SSP_IDLE)
    else $error("busy write started a transfer");

  overrun_set_a: assert property (
    frame_done && state_reg.rx_unread |=> state_reg.overrun_flag)
    else $error("overrun not flagged");

  overrun_hold_a: assert property (
    state_reg.overrun_flag && !wr_stat |=> state_reg.overrun_flag)
    else $error("overrun cleared without software");

  w1c_clear_a: assert property (
    wr_irq && state_reg.w_data[ssp_pkg::IRQ_TX_DONE_BIT] && !ev_tx_done |=>
      !state_reg.irq_request[ssp_pkg::IRQ_TX_DONE_BIT])
    else $error("request bit not cleared by write one");

  irq_out_a: assert property (
    irq == |(state_reg.irq_request & state_reg.irq_enable))
    else $error("interrupt output disagrees with requests");

  div8_half_a: assert property (
    $changed(state_reg.sclk) && state_reg.phase == ssp_pkg::SSP_SHIFT && !state_reg.slave_select_bit &&
      state_reg.shift_clock_divider_sel == 2'b00 |=> $stable(state_reg.sclk) [*3])
    else $error("master clock half period wrong");

  count_idle_a: assert property (
    state_reg.phase == ssp_pkg::SSP_IDLE |-> state_reg.shift_count == 3'h0)
    else $error("shift count nonzero while idle");

  count_step_a: assert property (
    $changed(state_reg.shift_count) |->
      state_reg.shift_count == 3'h0 || state_reg.shift_count == $past(state_reg.shift_count) + 3'h1)
    else $error("shift count skipped a value");

  rx_hold_a: assert property (!frame_done |=> $stable(state_reg.rx_buf))
    else $error("receive buffer changed without a frame");

  clk_idle_a: assert property (state_reg.phase == ssp_pkg::SSP_IDLE |-> state_reg.sclk)
    else $error("shift clock not high while idle");

  overrun_clear_a: assert property (
    wr_stat && !state_reg.w_data[ssp_pkg::STAT_OVERRUN_BIT] && !ev_overrun |=> !state_reg.overrun_flag)
    else $error("overrun not cleared by write zero");

endmodule

// ===== verification/ssp_peer.sv
module ssp_peer (
  input wire logic clk,
  input wire logic sclk_line,
  input wire logic tx_line,
  input wire logic msb_first,
  input wire logic [7:0] send_byte,
  output logic rx_line,
  output logic sclk_drv,
  output logic [7:0] got_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  logic active = 1'b0;

  initial begin
    rx_line = 1'b0;
    sclk_drv = 1'b1;
    got_byte = 8'h00;
  end

  // ==========================================================
  // Frame shifting: out on the falling edge, in on the rising edge
  always @(negedge sclk_line) begin
    active = 1'b1;
    rx_line = msb_first ? send_byte[7 - idx] : send_byte[idx];
  end

  always @(posedge sclk_line) begin
    if (active) begin
      got_byte = msb_first ? {got_byte[6:0], tx_line} : {tx_line, got_byte[7:1]};
      idx = idx + 1;
      if (idx == 8) begin
        idx = 0;
        active = 1'b0;
      end
    end
  end

  // Outside a frame the line toggles so stale data cannot pass for valid bits
  always @(posedge clk) begin
    if (!active) rx_line <= ~rx_line;
  end

  // ==========================================================
  // Slave-mode clock: eight periods, each level held eight bus cycles
  task automatic gen_frame();
    idx = 0;
    active = 1'b0;
    for (int i = 0; i < 8; i++) begin
      sclk_drv <= 1'b0;
      repeat (8) @(posedge clk);
      sclk_drv <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule

// ===== verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic serial_rx_in, serial_tx_out, sclk_out, sclk_oe, irq, peer_sclk, sclk_line, msb = 1'b0;
  logic [7:0] rd, peer_byte = 8'h00, peer_got, lowcnt = 8'h00, halfp = 8'h00;
  int mismatches = 0;
  int num_checks = 0;

  always #12.5 clk = ~clk;
  assign sclk_line = sclk_oe ? sclk_out : peer_sclk;

  ssp_sync_serial_port i_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_rx_in,
    .serial_tx_out, .sclk_in(sclk_line), .sclk_out, .sclk_oe, .irq);
  ssp_peer i_peer (.clk, .sclk_line, .tx_line(serial_tx_out), .msb_first(msb), .send_byte(peer_byte),
    .rx_line(serial_rx_in), .sclk_drv(peer_sclk), .got_byte(peer_got));

  // Length of the latest low phase of the master clock
  always @(posedge clk) begin
    if (!sclk_out) lowcnt <= lowcnt + 8'h01;
    else begin
      if (lowcnt != 8'h00) halfp <= lowcnt;
      lowcnt <= 8'h00;
    end
  end

  // ==========================================================
  // Bus and check tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    logic a_p, w_p;
    a_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (a_p || w_p) begin
      @(posedge clk);
      if (s_axi_awready) a_p = 1'b0;
      if (s_axi_wready) w_p = 1'b0;
      s_axi_awvalid <= a_p;
      s_axi_wvalid <= w_p;
    end
    while (!s_axi_bvalid) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdreg(input logic [31:0] a, output logic [7:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 200; k++) begin
      rdreg(ssp_pkg::ADDR_STATUS, rd, resp);
      if (rd[0] === 1'b0) break;
    end
    chk("status idle", 8'h00, rd & 8'he1);
  endtask

  task automatic xfer(input logic [1:0] sel, input logic m, input logic [7:0] d, input logic [7:0] p);
    msb <= m;
    peer_byte <= p;
    wr(ssp_pkg::ADDR_CONTROL, {2'h0, m, 1'b0, 2'h0, sel}, resp);
    wr(ssp_pkg::ADDR_DATA_BUFFER, d, resp);
    wait_idle();
    chk("half period", (sel == 2'h0) ? 8'h04 : (sel == 2'h1) ? 8'h08 : 8'h10, halfp);
    chk("peer byte", d, peer_got);
    rdreg(ssp_pkg::ADDR_IRQ_REQUEST, rd, resp);
    chk("requests", 8'h07, rd);
    wr(ssp_pkg::ADDR_IRQ_REQUEST, 8'h07, resp);
    rdreg(ssp_pkg::ADDR_IRQ_REQUEST, rd, resp);
    chk("requests cleared", 8'h00, rd);
    rdreg(ssp_pkg::ADDR_DATA_BUFFER, rd, resp);
    chk("rx byte", p, rd);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #500us;
    mismatches++;
    summarize();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      rdreg(ssp_pkg::ADDR_DATA_BUFFER + 32'(4 * i), rd, resp);
      chk("reset value", ssp_pkg::REG_RESET, rd);
    end
    rdreg(32'hb7b01018, rd, resp);
    chk("unmapped read", ssp_pkg::RESP_SLVERR, resp);
    wr(32'hb7b01018, 8'h00, resp);
    chk("unmapped write", ssp_pkg::RESP_SLVERR, resp);
    wr(ssp_pkg::ADDR_CONTROL, 8'h33, resp);
    rdreg(ssp_pkg::ADDR_CONTROL, rd, resp);
    chk("control", 8'h33, rd);
    for (int s = 0; s < 4; s++) xfer(2'(s), s[0], 8'h5a ^ 8'(s), 8'hc3 + 8'(s));
    wr(ssp_pkg::ADDR_IRQ_ENABLE, 8'h01, resp);
    wr(ssp_pkg::ADDR_DATA_BUFFER, 8'h3c, resp);
    wait_idle();
    chk("irq tx done", 1'b1, irq);
    wr(ssp_pkg::ADDR_IRQ_ENABLE, 8'h04, resp);
    chk("irq empty", 1'b1, irq);
    wr(ssp_pkg::ADDR_IRQ_REQUEST, 8'h04, resp);
    chk("irq masked", 1'b0, irq);
    wr(ssp_pkg::ADDR_IRQ_ENABLE, 8'h02, resp);
    chk("irq rx done", 1'b1, irq);
    wr(ssp_pkg::ADDR_IRQ_REQUEST, 8'h03, resp);
    chk("irq cleared", 1'b0, irq);
    xfer(2'h0, 1'b0, 8'ha5, 8'h69);
    rdreg(ssp_pkg::ADDR_STATUS, rd, resp);
    chk("overrun set", 8'h02, rd);
    xfer(2'h1, 1'b1, 8'h0f, 8'hf0);
    rdreg(ssp_pkg::ADDR_STATUS, rd, resp);
    chk("overrun held", 8'h02, rd);
    wr(ssp_pkg::ADDR_STATUS, 8'he0, resp);
    rdreg(ssp_pkg::ADDR_STATUS, rd, resp);
    chk("overrun write zero", 8'h00, rd);
    wr(ssp_pkg::ADDR_STATUS, 8'h02, resp);
    rdreg(ssp_pkg::ADDR_STATUS, rd, resp);
    chk("overrun write one", 8'h02, rd);
    wr(ssp_pkg::ADDR_STATUS, 8'h01, resp);
    rdreg(ssp_pkg::ADDR_STATUS, rd, resp);
    chk("busy write idle", 8'h00, rd);
    wr(ssp_pkg::ADDR_CONTROL, 8'h02, resp);
    wr(ssp_pkg::ADDR_DATA_BUFFER, 8'h81, resp);
    repeat (80) @(posedge clk);
    rdreg(ssp_pkg::ADDR_STATUS, rd, resp);
    chk("busy mid frame", 1'b1, rd[0]);
    wr(ssp_pkg::ADDR_STATUS, 8'h00, resp);
    rdreg(ssp_pkg::ADDR_STATUS, rd, resp);
    chk("abort status", 8'h00, rd);
    chk("abort clock", 1'b1, sclk_out);
    msb <= 1'b0;
    wr(ssp_pkg::ADDR_CONTROL, 8'h10, resp);
    wr(ssp_pkg::ADDR_TEST_CONTROL, 8'h80, resp);
    rdreg(ssp_pkg::ADDR_TEST_CONTROL, rd, resp);
    chk("test control", 8'h80, rd);
    chk("clock released", 1'b0, sclk_oe);
    wr(ssp_pkg::ADDR_DATA_BUFFER, 8'h96, resp);
    repeat (4) @(posedge clk);
    i_peer.gen_frame();
    wait_idle();
    rdreg(ssp_pkg::ADDR_DATA_BUFFER, rd, resp);
    chk("loopback byte", 8'h96, rd);
    chk("slave tx byte", 8'h96, peer_got);
    summarize();
  end
endmodule
